// [core/fifo_core.sv]
// Bus-matching FIFO with strap configuration, almost flags, offsets and Wishbone status
`timescale 1ns/10ps
`default_nettype none
`include "fifo_params.svh"

// Overview of operation
// - Output enable low drives read data, high releases the data lines.
// - Read width strap taken at master reset: low wide, high narrow.
// - Almost-empty low while stored count is below the empty offset.
// - Almost-full high while free locations exceed the full offset.
// - Flag timing strap taken at master reset: almost flags low asynchronous, high synchronous; empty and full always registered.
// - Partial reset zeroes both pointers and the output data register.
// - Partial reset keeps mode, programming method and offsets.
// - Narrow read width presents data only on the lowest nine lines.
// - Read actions occur only with read enable low.
// - Synchronous read takes one word per enabled read clock edge.
// - Offset access low outputs offset registers instead of buffer data.
// - Asynchronous read takes one word per rising read strobe edge.
// - Retransmit timing strap taken at master reset but unused: retransmit behaves the same at either level.
// - Retransmit zeroes read pointer and forces empty or output-valid flag.
// - Retransmit keeps write pointer, method, timing and offsets.
// - Offsets shift in serially only while serial enable is low.
// - Synchronous write stores one word per enabled write clock edge.
// - Asynchronous write stores one word per rising write strobe edge.
// - Write actions occur only with write enable low.
// - Empty output means empty in standard mode, data valid in fall-through.
// - Full output means full in standard mode, space left in fall-through.
// - Write width strap taken at master reset: low wide, high narrow.
module fifo_core #(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int ADDR_W = `FIFO_ADDR_W
) (
  // Clock, clock enable, master reset
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_sys_rst,
  // Straps sampled after master reset
  input wire logic i_read_width_select,
  input wire logic i_write_width_select,
  input wire logic i_flag_timing_select,
  input wire logic i_retransmit_timing_select,
  input wire logic i_async_read_n,
  input wire logic i_async_write_n,
  // Fall-through strap, serial offset data afterwards
  input wire logic i_fall_through_mode,
  // Write port
  input wire logic [`FIFO_DATA_W-1:0] i_write_data,
  input wire logic i_write_en_n,
  input wire logic i_write_strobe,
  // Read port
  input wire logic i_read_en_n,
  input wire logic i_read_strobe,
  input wire logic i_output_en_n,
  output logic [`FIFO_DATA_W-1:0] o_read_data_out,
  output logic o_read_data_oe,
  // Control pins
  input wire logic i_partial_reset_n,
  input wire logic i_replay_from_start_n,
  input wire logic i_offset_access_select_n,
  input wire logic i_serial_offset_enable_n,
  // Flags
  output logic o_empty_flag,
  output logic o_full_flag,
  output logic o_almost_empty_flag,
  output logic o_almost_full_flag,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack
);

  localparam int CW = ADDR_W + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_C = CW'(1);

  logic [`FIFO_DATA_W-1:0] mem [DEPTH];
  fifo_pkg::cfg_t cfg;
  fifo_pkg::flags_t flags;
  logic cfg_taken;
  logic [ADDR_W-1:0] wr_ptr;
  logic [ADDR_W-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [ADDR_W-1:0] empty_off;
  logic [ADDR_W-1:0] full_off;
  logic [`FIFO_DATA_W-1:0] rdata;
  logic wr_strobe_d;
  logic rd_strobe_d;
  logic wr_ofs_sel;
  logic rd_ofs_sel;
  logic soft_prs;
  logic soft_rt;
  logic empty;
  logic full;
  logic wr_req;
  logic rd_req;
  logic wr_go;
  logic rd_go;
  logic partial_reset;
  logic rt;
  logic pae_now;
  logic paf_now;
  logic [CW-1:0] free_cnt;
  logic [ADDR_W-1:0] next_rd_ptr;
  logic wb_req;

  // Straps caught on the first enabled edge after master reset
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg <= '0;
      cfg_taken <= 1'b0;
    end else if (i_ce && !cfg_taken) begin
      cfg.read_narrow <= i_read_width_select;
      cfg.write_narrow <= i_write_width_select;
      cfg.flag_sync <= i_flag_timing_select;
      cfg.retransmit_normal <= i_retransmit_timing_select;
      cfg.fall_through_mode <= i_fall_through_mode;
      cfg.async_read <= !i_async_read_n;
      cfg.async_write <= !i_async_write_n;
      cfg_taken <= 1'b1;
    end
  end

  // Strobe history for edge detection in asynchronous port modes
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_strobe_d <= 1'b0;
      rd_strobe_d <= 1'b0;
    end else if (i_ce) begin
      wr_strobe_d <= i_write_strobe;
      rd_strobe_d <= i_read_strobe;
    end
  end

  // Request decode, including enables held by the far side in strobe modes
  always_comb begin
    empty = (count == '0);
    full = (count == DEPTH_C);
    partial_reset = !i_partial_reset_n || soft_prs;
    rt = (!i_replay_from_start_n || soft_rt) && !partial_reset;
    wr_req = (cfg.async_write ? (i_write_strobe && !wr_strobe_d) : 1'b1)
             && !i_write_en_n && cfg_taken && i_ce;
    rd_req = (cfg.async_read ? (i_read_strobe && !rd_strobe_d) : 1'b1)
             && !i_read_en_n && cfg_taken && i_ce;
    wr_go = wr_req && i_offset_access_select_n && !full && !partial_reset;
    rd_go = rd_req && i_offset_access_select_n && !empty && !partial_reset && !rt;
    next_rd_ptr = rd_ptr + ADDR_W'(1);
    free_cnt = DEPTH_C - count;
    pae_now = (count >= CW'(empty_off));
    paf_now = (free_cnt > CW'(full_off));
  end

  // Storage, narrow writes keep the low nine bits
  always_ff @(posedge i_clk) begin
    if (wr_go) begin
      mem[wr_ptr] <= cfg.write_narrow ? (i_write_data & `FIFO_NARROW_MASK) : i_write_data;
    end
  end

  // Write pointer, untouched by retransmit
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
    end else if (i_ce) begin
      if (partial_reset) begin
        wr_ptr <= '0;
      end else if (wr_go) begin
        wr_ptr <= wr_ptr + ADDR_W'(1);
      end
    end
  end

  // Read pointer and word count
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_ptr <= '0;
      count <= '0;
    end else if (i_ce) begin
      if (partial_reset) begin
        rd_ptr <= '0;
        count <= '0;
      end else if (rt) begin
        rd_ptr <= '0;
        count <= full ? DEPTH_C : CW'(wr_ptr) + (wr_go ? ONE_C : '0);
      end else begin
        if (rd_go) begin
          rd_ptr <= next_rd_ptr;
        end
        count <= count + (wr_go ? ONE_C : '0) - (rd_go ? ONE_C : '0);
      end
    end
  end

  // Offset registers: serial shift, parallel write, kept by partial reset
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      empty_off <= ADDR_W'(`FIFO_DEF_EMPTY_OFFSET);
      full_off <= ADDR_W'(`FIFO_DEF_FULL_OFFSET);
      wr_ofs_sel <= 1'b0;
    end else if (i_ce && cfg_taken && !partial_reset) begin
      if (!i_serial_offset_enable_n) begin
        {full_off, empty_off} <= {i_fall_through_mode, full_off, empty_off[ADDR_W-1:1]};
      end else if (wr_req && !i_offset_access_select_n) begin
        if (wr_ofs_sel) begin
          full_off <= i_write_data[ADDR_W-1:0];
        end else begin
          empty_off <= i_write_data[ADDR_W-1:0];
        end
        wr_ofs_sel <= !wr_ofs_sel;
      end
    end
  end

  // Output data register: buffer word, offset readback or fall-through head
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata <= '0;
      rd_ofs_sel <= 1'b0;
    end else if (i_ce) begin
      if (partial_reset) begin
        rdata <= '0;
        rd_ofs_sel <= 1'b0;
      end else if (rd_req && !i_offset_access_select_n) begin
        rdata <= `FIFO_DATA_W'(rd_ofs_sel ? full_off : empty_off);
        rd_ofs_sel <= !rd_ofs_sel;
      end else if (cfg.fall_through_mode && !empty && !rt) begin
        rdata <= rd_go ? mem[next_rd_ptr] : mem[rd_ptr];
      end else if (rd_go) begin
        rdata <= mem[rd_ptr];
      end
    end
  end

  // Data outputs and drive enable
  always_comb begin
    o_read_data_out = cfg.read_narrow ? (rdata & `FIFO_NARROW_MASK) : rdata;
    o_read_data_oe = !i_output_en_n;
  end

  // Registered flags; almost flags also available without register delay
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flags <= '0;
    end else if (i_ce) begin
      if (rt) begin
        flags.empty_flag <= cfg.fall_through_mode;
      end else begin
        flags.empty_flag <= cfg.fall_through_mode ? empty : !empty;
      end
      flags.full_flag <= cfg.fall_through_mode ? full : !full;
      flags.almost_empty_flag <= pae_now;
      flags.almost_full_flag <= paf_now;
    end
  end

  // Flag outputs, almost flags steered by the timing strap
  always_comb begin
    o_empty_flag = flags.empty_flag;
    o_full_flag = flags.full_flag;
    o_almost_empty_flag = cfg.flag_sync ? flags.almost_empty_flag : pae_now;
    o_almost_full_flag = cfg.flag_sync ? flags.almost_full_flag : paf_now;
  end

  // Wishbone slave: one-cycle pulses for soft partial reset and retransmit
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
      soft_prs <= 1'b0;
      soft_rt <= 1'b0;
    end else if (i_ce) begin
      o_wb_ack <= wb_req;
      soft_prs <= 1'b0;
      soft_rt <= 1'b0;
      o_wb_dat <= '0;
      if (wb_req && i_wb_we && i_wb_adr == `FIFO_REG_CTRL && i_wb_sel[0]) begin
        soft_prs <= i_wb_dat[`FIFO_CTRL_PRS_BIT];
        soft_rt <= i_wb_dat[`FIFO_CTRL_RT_BIT];
      end
      if (wb_req && !i_wb_we) begin
        unique case (i_wb_adr)
          `FIFO_REG_STATUS: begin
            o_wb_dat <= 32'(count);
            o_wb_dat[`FIFO_STAT_EMPTY_BIT] <= empty;
            o_wb_dat[`FIFO_STAT_FULL_BIT] <= full;
            o_wb_dat[`FIFO_STAT_AE_BIT] <= pae_now;
            o_wb_dat[`FIFO_STAT_AF_BIT] <= paf_now;
            o_wb_dat[`FIFO_STAT_FALL_THROUGH_MODE_BIT] <= cfg.fall_through_mode;
          end
          `FIFO_REG_EMPTY_OFS: o_wb_dat <= 32'(empty_off);
          `FIFO_REG_FULL_OFS: o_wb_dat <= 32'(full_off);
          default: o_wb_dat <= '0;
        endcase
      end
    end
  end

  // Checks
  AST_OE_RELEASE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_output_en_n |-> !o_read_data_oe) else $error("data driven while output enable high");
  AST_NARROW_READ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cfg_taken && cfg.read_narrow |-> o_read_data_out[17:9] == 9'h000)
    else $error("narrow read drives upper lines");
  AST_AE_LOW: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !cfg.flag_sync && count < CW'(empty_off) |-> !o_almost_empty_flag)
    else $error("almost-empty high below offset");
  AST_AF_LOW: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cfg.flag_sync && i_ce && free_cnt <= CW'(full_off) |=> !o_almost_full_flag)
    else $error("almost-full high within offset");
  AST_PRS_CLEAR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_ce && partial_reset |=> wr_ptr == '0 && rd_ptr == '0 && rdata == '0)
    else $error("partial reset left pointers or data");
  AST_PRS_KEEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cfg_taken && partial_reset |=> $stable(empty_off) && $stable(full_off) && $stable(cfg))
    else $error("partial reset altered settings");
  AST_RT_POINTERS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_ce && rt && !wr_go |=> rd_ptr == '0 && $stable(wr_ptr) && $stable(empty_off))
    else $error("retransmit pointer handling wrong");
  AST_READ_STEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    rd_go |=> rd_ptr == $past(next_rd_ptr) && count <= $past(count))
    else $error("read did not advance");
  AST_WRITE_STEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_go && !rd_go && !rt |=> count == $past(count) + ONE_C)
    else $error("write did not count");
  AST_FULL_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    full && !partial_reset |=> $stable(wr_ptr))
    else $error("write accepted while full");

  // Enable, flag and freeze checks
  AST_CE_FREEZE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_ce |=> $stable(count) && $stable(wr_ptr) && $stable(rd_ptr) && $stable(rdata))
    else $error("state moved while clock enable low");
  AST_RT_FLAG: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_ce && rt |=> o_empty_flag == cfg.fall_through_mode)
    else $error("retransmit did not force the empty flag");
  AST_SERIAL_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_ce && i_serial_offset_enable_n && i_offset_access_select_n |=> $stable(empty_off) && $stable(full_off))
    else $error("offsets changed without a load");
  AST_RD_ENABLE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_read_en_n && !partial_reset && !rt |=> $stable(rd_ptr))
    else $error("read pointer moved without read enable");
  AST_WR_ENABLE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_write_en_n && !partial_reset |=> $stable(wr_ptr))
    else $error("write pointer moved without write enable");
  AST_EMPTY_FLAG: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_ce && !rt && !cfg.fall_through_mode |=> o_empty_flag == !$past(empty))
    else $error("empty flag does not follow the word count");
  AST_FULL_FLAG: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_ce && !cfg.fall_through_mode |=> o_full_flag == !$past(full))
    else $error("full flag does not follow the word count");
  AST_NO_READ_EMPTY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    empty && !partial_reset && !rt |=> $stable(rd_ptr))
    else $error("read accepted while empty");
  AST_AE_HIGH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cfg.flag_sync && i_ce && count >= CW'(empty_off) |=> o_almost_empty_flag)
    else $error("almost-empty low at or above offset");
  AST_AF_HIGH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cfg_taken && !cfg.flag_sync && free_cnt > CW'(full_off) |-> o_almost_full_flag)
    else $error("almost-full low with space above offset");
  AST_OFS_READBACK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    rd_req && !partial_reset && !i_offset_access_select_n && !rd_ofs_sel |=> rdata == `FIFO_DATA_W'($past(empty_off)))
    else $error("offset readback shows wrong value");

endmodule : fifo_core

`default_nettype wire

// [core/fifo_params.svh]
// Constants for the bus-matching FIFO: widths, masks, register offsets, reset values
`ifndef FIFO_PARAMS_SVH
`define FIFO_PARAMS_SVH

// Data path
`define FIFO_DATA_W 18
`define FIFO_NARROW_MASK 18'h001FF
`define FIFO_DEPTH 131072
`define FIFO_ADDR_W 17

// Default almost-empty and almost-full offsets after master reset
`define FIFO_DEF_EMPTY_OFFSET 17'h0007F
`define FIFO_DEF_FULL_OFFSET 17'h0007F

// Register byte offsets on the bus
`define FIFO_REG_CTRL 4'h0
`define FIFO_REG_STATUS 4'h4
`define FIFO_REG_EMPTY_OFS 4'h8
`define FIFO_REG_FULL_OFS 4'hC

// Control register fields
`define FIFO_CTRL_PRS_BIT 0
`define FIFO_CTRL_RT_BIT 1

// Status register fields
`define FIFO_STAT_EMPTY_BIT 24
`define FIFO_STAT_FULL_BIT 25
`define FIFO_STAT_AE_BIT 26
`define FIFO_STAT_AF_BIT 27
`define FIFO_STAT_FALL_THROUGH_MODE_BIT 28

`endif

// [core/fifo_pkg.sv]
// Types shared by the bus-matching FIFO
package fifo_pkg;

  // Configuration captured at master reset
  typedef struct packed {
    logic fall_through_mode;
    logic read_narrow;
    logic write_narrow;
    logic flag_sync;
    logic retransmit_normal;
    logic async_read;
    logic async_write;
  } cfg_t;

  // Registered flag outputs
  typedef struct packed {
    logic empty_flag;
    logic full_flag;
    logic almost_empty_flag;
    logic almost_full_flag;
  } flags_t;

endpackage : fifo_pkg

// [dv/dual_clock_bus_matching_fifo_bench.sv]
// Self-checking bench for the FIFO core and its port partner
`timescale 1ns/10ps
`default_nettype none
`include "fifo_params.svh"
module dual_clock_bus_matching_fifo_bench;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic narrow = 1'b0, flag_timing_select = 1'b1, rtm = 1'b0, oe_n = 1'b0, prs_n = 1'b1, rt_n = 1'b1;
  logic ld_n = 1'b1, sen_n = 1'b1, ser = 1'b0, go_w = 1'b0, go_r = 1'b0;
  logic cyc = 1'b0, we = 1'b0;
  logic ce = 1'b1, asy_n = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, got;
  logic [17:0] word = 18'h0, wdata, q, d;
  logic [17:0] mem [16];
  logic wen_n, ren_n, oe, ef, ff, ae, af, ack;
  int num_errors = 0, n_checks = 0, seed = 81, n;

  // Free-running clock
  always #25 i_clk = ~i_clk;

  // Design under test with a short buffer
  fifo_core #(.DEPTH(16), .ADDR_W(4)) u_dut (
    .i_clk(i_clk), .i_ce(ce), .i_sys_rst(i_sys_rst),
    .i_read_width_select(narrow), .i_write_width_select(narrow),
    .i_flag_timing_select(flag_timing_select), .i_retransmit_timing_select(rtm),
    .i_async_read_n(asy_n), .i_async_write_n(asy_n), .i_fall_through_mode(ser),
    .i_write_data(wdata), .i_write_en_n(wen_n), .i_write_strobe(wr_stb),
    .i_read_en_n(ren_n), .i_read_strobe(rd_stb), .i_output_en_n(oe_n),
    .o_read_data_out(q), .o_read_data_oe(oe), .i_partial_reset_n(prs_n),
    .i_replay_from_start_n(rt_n), .i_offset_access_select_n(ld_n),
    .i_serial_offset_enable_n(sen_n), .o_empty_flag(ef), .o_full_flag(ff),
    .o_almost_empty_flag(ae), .o_almost_full_flag(af), .i_wb_cyc(cyc),
    .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack));

  // Producer and consumer on the data ports
  fifo_stream_partner u_partner (.i_clk(i_clk), .i_rst(i_sys_rst), .i_go_write(go_w),
    .i_go_read(go_r), .i_word(word), .o_write_data(wdata), .o_write_en_n(wen_n),
    .o_read_en_n(ren_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // Master reset; straps stay put until the next one
  task automatic mrst(input logic nar, input logic asy_n_in);
    i_sys_rst <= 1'b1;
    narrow <= nar;
    flag_timing_select <= !nar;
    rtm <= nar;
    asy_n <= asy_n_in;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask : mrst

  // Classic Wishbone single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] dw);
    int k;
    @(posedge i_clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dw;
    sel <= 4'($random(seed)) | 4'h1; // Lane 0 always on for control writes
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (ack === 1'b1) break;
    end
    if (k == 20) begin
      num_errors++;
      wrap_up();
    end
    got = rdat;
    cyc <= 1'b0;
  endtask : wb

  // One write and/or read through the partner, then flags settle
  task automatic op(input logic w, input logic r, input logic [17:0] dw);
    @(posedge i_clk);
    go_w <= w;
    go_r <= r;
    word <= dw;
    @(posedge i_clk);
    go_w <= 1'b0;
    go_r <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : op

  // Main sequence
  initial begin
    mrst(1'b0, 1'b1);
    check(32'(ef), 32'h0);
    check(32'(ff), 32'h1);
    for (int i = 0; i < 2; i++) begin
      @(posedge i_clk);
      oe_n <= i[0];
      @(posedge i_clk);
      check(32'(oe), 32'(!oe_n));
    end
    // Serial offsets, LSB first: empty 4, full 3, then noise with loading disabled
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      sen_n <= 1'b0;
      ser <= (i < 4) ? (i == 2) : (i - 4 < 2);
    end
    @(posedge i_clk);
    sen_n <= 1'b1;
    ser <= 1'b1;
    repeat (4) @(posedge i_clk);
    ser <= 1'b0;
    wb(1'b0, 4'h8, 32'h0);
    check(got, 32'h4);
    wb(1'b0, 4'hC, 32'h0);
    check(got, 32'h3);
    // Offset readback through the read port: empty first, then full
    ld_n <= 1'b0;
    op(1'b0, 1'b1, 18'h0);
    check(32'(q), 32'h4);
    op(1'b0, 1'b1, 18'h0);
    check(32'(q), 32'h3);
    ld_n <= 1'b1;
    // Fill one past full
    for (int k = 1; k <= 17; k++) begin
      d = 18'($random(seed));
      if (k <= 16) mem[k-1] = d;
      op(1'b1, 1'b0, d);
      n = (k > 16) ? 16 : k;
      check(32'(ae), 32'(n >= 4));
      check(32'(af), 32'(16 - n > 3));
      check(32'(ff), 32'(n != 16));
      check(32'(ef), 32'h1);
    end
    wb(1'b0, 4'h4, 32'h0);
    check(got & 32'h3FFFF, 32'h10);
    // Drain and read once past empty
    for (int k = 0; k < 17; k++) begin
      op(1'b0, 1'b1, 18'h0);
      check(32'(q), 32'(mem[k < 16 ? k : 15]));
    end
    check(32'(ef), 32'h0);
    // Write attempt with the clock enable low leaves the buffer empty
    ce <= 1'b0;
    op(1'b1, 1'b0, 18'h3FFFF);
    ce <= 1'b1;
    wb(1'b0, 4'h4, 32'h0);
    check(got & 32'h3FFFF, 32'h0);
    // Partial reset with data stored
    op(1'b1, 1'b0, 18'h2AAAA);
    op(1'b1, 1'b1, 18'h15555);
    @(posedge i_clk);
    prs_n <= 1'b0;
    @(posedge i_clk);
    prs_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    check(32'(q), 32'h0);
    check(32'(ef), 32'h0);
    wb(1'b0, 4'h8, 32'h0);
    check(got, 32'h4);
    // Retransmit after one read
    for (int k = 0; k < 3; k++) begin
      mem[k] = 18'($random(seed));
      op(1'b1, 1'b0, mem[k]);
    end
    op(1'b0, 1'b1, 18'h0);
    check(32'(q), 32'(mem[0]));
    @(posedge i_clk);
    rt_n <= 1'b0;
    @(posedge i_clk);
    rt_n <= 1'b1;
    @(posedge i_clk);
    check(32'(ef), 32'h0);
    wb(1'b0, 4'h4, 32'h0);
    check(got & 32'h3FFFF, 32'h3);
    for (int k = 0; k < 3; k++) begin
      op(1'b0, 1'b1, 18'h0);
      check(32'(q), 32'(mem[k]));
    end
    // Soft retransmit through the control register
    wb(1'b1, 4'h0, 32'h2);
    wb(1'b0, 4'h4, 32'h0);
    check(got & 32'h3FFFF, 32'h3);
    op(1'b0, 1'b1, 18'h0);
    check(32'(q), 32'(mem[0]));
    // Narrow ports after a second master reset
    mrst(1'b1, 1'b1);
    d = 18'($random(seed)) | 18'h3FE00;
    op(1'b1, 1'b0, d);
    op(1'b0, 1'b1, 18'h0);
    check(32'(q), 32'(d & `FIFO_NARROW_MASK));
    wb(1'b0, 4'h2, 32'h0);
    check(got, 32'h0);
    // Strobe-driven ports: enables held low, one word per strobe edge
    mrst(1'b0, 1'b0);
    d = 18'($random(seed));
    @(posedge i_clk);
    go_w <= 1'b1;
    go_r <= 1'b1;
    word <= d;
    repeat (3) @(posedge i_clk);
    wr_stb <= 1'b1;
    @(posedge i_clk);
    wr_stb <= 1'b0;
    wb(1'b0, 4'h4, 32'h0);
    check(got & 32'h3FFFF, 32'h1);
    @(posedge i_clk);
    rd_stb <= 1'b1;
    @(posedge i_clk);
    rd_stb <= 1'b0;
    repeat (2) @(posedge i_clk);
    check(32'(q), 32'(d));
    wb(1'b0, 4'h4, 32'h0);
    check(got & 32'h3FFFF, 32'h0);
    @(posedge i_clk);
    go_w <= 1'b0;
    go_r <= 1'b0;
    // Fall-through mode: head word shown without a read
    ser <= 1'b1;
    mrst(1'b0, 1'b1);
    ser <= 1'b0;
    @(posedge i_clk);
    check(32'(ef), 32'h1);
    check(32'(ff), 32'h0);
    d = 18'($random(seed));
    op(1'b1, 1'b0, d);
    check(32'(q), 32'(d));
    check(32'(ef), 32'h0);
    op(1'b0, 1'b1, 18'h0);
    check(32'(ef), 32'h1);
    wrap_up();
  end
endmodule : dual_clock_bus_matching_fifo_bench
`default_nettype wire

// [dv/fifo_stream_partner.sv]
// Producer and consumer logic for the FIFO write and read ports
`timescale 1ns/10ps
`default_nettype none
`include "fifo_params.svh"
module fifo_stream_partner (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Requests from the bench
  input wire logic i_go_write,
  input wire logic i_go_read,
  input wire logic [`FIFO_DATA_W-1:0] i_word,
  // Synchronous port signals, no strobes used
  output logic [`FIFO_DATA_W-1:0] o_write_data,
  output logic o_write_en_n,
  output logic o_read_en_n
);
  // One request per cycle; data toggles when no write is pending
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_write_en_n <= 1'b1;
      o_read_en_n <= 1'b1;
      o_write_data <= '0;
    end else begin
      o_write_en_n <= !i_go_write;
      o_read_en_n <= !i_go_read;
      o_write_data <= i_go_write ? i_word : ~o_write_data;
    end
  end
endmodule : fifo_stream_partner
`default_nettype wire
